//--- rtl/tw8_timer.v
/*
 * 8-bit timer/counter with normal, clear-on-match, fast PWM and
 * phase-correct PWM modes, overflow and compare flags and a waveform pin.
 * Assumes a classic Wishbone master on clk_i and a timer clock enable
 * from a prescaler on the same clock.
 */
`timescale 1ns/1ps
`include "tw8_timer_regs.vh"

module tw8_timer
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Timer clock enable and interrupt service
  input wire tick_i,
  input wire ovf_ack_i,
  input wire cmp_ack_i,
  // Flags
  output wire ovf_flag_o,
  output wire cmp_flag_o,
  // Waveform and port pin
  output reg wave_o,
  output reg pin_o,
  output reg pin_oe_n_o
);

  // ============================================================
  // Register state
  reg [7:0] ctrl;
  reg [7:0] count;
  reg up;
  reg up_matched;
  reg blocked;
  reg dir_out;
  wire [7:0] cmp_buf;
  wire [7:0] cmp_act;

  // Decoded control fields
  wire [1:0] mode;
  wire [1:0] osel;
  wire pwm;
  assign mode = {ctrl[`TW8_CTRL_MODE_HI], ctrl[`TW8_CTRL_MODE_LO]};
  assign osel = {ctrl[`TW8_CTRL_OSEL_HI], ctrl[`TW8_CTRL_OSEL_LO]};
  assign pwm = mode[0];

  // ============================================================
  // Bus access decode
  wire acc;
  wire wr;
  wire wr_ctrl;
  wire wr_count;
  wire wr_cmp;
  wire wr_flags;
  wire wr_dir;
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign wr_ctrl = wr && (wb_adr_i == `TW8_OFS_CTRL);
  assign wr_count = wr && (wb_adr_i == `TW8_OFS_COUNT);
  assign wr_cmp = wr && (wb_adr_i == `TW8_OFS_COMPARE);
  assign wr_flags = wr && (wb_adr_i == `TW8_OFS_FLAGS);
  assign wr_dir = wr && (wb_adr_i == `TW8_OFS_DIR);

  // Force strobe works only in the non-PWM modes
  wire force_cmp;
  assign force_cmp = wr_ctrl && wb_dat_i[`TW8_CTRL_FORCE] && !wb_dat_i[`TW8_CTRL_MODE_LO];

  // ============================================================
  // Compare match and extremes
  // A counter write masks the match on the next tick so software can
  // preload equal values without a spurious event
  wire match;
  wire at_max;
  wire at_bottom;
  wire advance;
  assign at_max = (count == `TW8_MAX);
  assign at_bottom = (count == `TW8_BOTTOM);
  assign match = (count == cmp_act) && !blocked;
  assign advance = tick_i && !wr_count;

  // Top strobe for loading the compare buffer in PWM modes
  wire top_load;
  assign top_load = advance && pwm && at_max;

  // Compare value seen after a top load, used for the top-of-count cases
  wire [7:0] cmp_next;
  assign cmp_next = top_load ? cmp_buf : cmp_act;

  // ============================================================
  // Counting sequence
  reg [7:0] next_count;
  reg next_up;
  reg set_ovf;
  reg set_cmp;
  always @*
  begin
    next_count = count;
    next_up = up;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    if (wr_count)
      next_count = wb_dat_i[7:0];
    else if (tick_i)
    begin
      set_cmp = match;
      case (mode)
        `TW8_MODE_NORMAL:
        begin
          next_count = count + 8'h01;
          set_ovf = at_max;
        end
        `TW8_MODE_CLEAR:
        begin
          // A compare below the count is missed until the wrap
          if (match)
            next_count = `TW8_BOTTOM;
          else
            next_count = count + 8'h01;
          set_ovf = at_max;
        end
        `TW8_MODE_FAST:
        begin
          if (at_max)
            next_count = `TW8_BOTTOM;
          else
            next_count = count + 8'h01;
          set_ovf = at_max;
        end
        `TW8_MODE_PHASE:
        begin
          // Full 8-bit range; MAX and bottom each last one tick
          if (up)
          begin
            if (at_max)
            begin
              next_up = 1'b0;
              next_count = `TW8_MAX - 8'h01;
            end
            else
              next_count = count + 8'h01;
          end
          else
          begin
            if (at_bottom)
            begin
              next_up = 1'b1;
              next_count = `TW8_BOTTOM + 8'h01;
            end
            else
              next_count = count - 8'h01;
          end
          set_ovf = at_bottom;
        end
        default:
        begin
          next_count = count;
        end
      endcase
    end
  end

  // ============================================================
  // Waveform generation
  // Match actions: 1 toggles, 2 clears, 3 sets; PWM modes reshape these
  reg next_wave;
  reg next_upm;
  reg ignore_top;
  reg up_eff;
  always @*
  begin
    next_wave = wave_o;
    next_upm = up_matched;
    ignore_top = (cmp_act == `TW8_MAX) && osel[1];
    up_eff = up || at_bottom;
    if (force_cmp)
    begin
      // Forced match changes only the output, never flags or counter
      case (wb_dat_i[`TW8_CTRL_OSEL_HI:`TW8_CTRL_OSEL_LO])
        2'h1: next_wave = !wave_o;
        2'h2: next_wave = 1'b0;
        2'h3: next_wave = 1'b1;
        default: next_wave = wave_o;
      endcase
    end
    else if (advance)
    begin
      case (mode)
        `TW8_MODE_NORMAL, `TW8_MODE_CLEAR:
        begin
          if (match && osel == 2'h1)
            next_wave = !wave_o;
          else if (match && osel == 2'h2)
            next_wave = 1'b0;
          else if (match && osel == 2'h3)
            next_wave = 1'b1;
        end
        `TW8_MODE_FAST:
        begin
          if (match && osel == 2'h1)
            next_wave = !wave_o;
          else if (match && osel[1] && !ignore_top)
            next_wave = osel[0];
          if (at_max && osel[1])
            next_wave = !osel[0];
        end
        `TW8_MODE_PHASE:
        begin
          // Bottom is treated as the start of the up slope
          if (match && osel[1] && !ignore_top)
          begin
            next_wave = up_eff ? osel[0] : !osel[0];
            if (up_eff)
              next_upm = 1'b1;
          end
          if (at_max && osel[1])
          begin
            if (cmp_next == `TW8_MAX)
              next_wave = !osel[0];
            else if (!up_matched)
              next_wave = osel[0];
          end
          if (at_max)
            next_upm = 1'b0;
        end
        default:
        begin
          next_wave = wave_o;
        end
      endcase
    end
  end

  // ============================================================
  // Counter, direction and match blocking
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= `TW8_RST_COUNT;
      up <= 1'b1;
      up_matched <= 1'b0;
      blocked <= 1'b0;
      wave_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      up <= next_up;
      up_matched <= next_upm;
      wave_o <= next_wave;
      // Block lasts until the next tick that follows the write
      if (wr_count)
        blocked <= 1'b1;
      else if (tick_i)
        blocked <= 1'b0;
    end
  end

  // ============================================================
  // Compare value store
  tw8_cmp_buf u_cmp
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_cmp),
    .wdata_i(wb_dat_i[7:0]),
    .pwm_i(pwm),
    .load_i(top_load),
    .buf_o(cmp_buf),
    .active_o(cmp_act)
  );

  // ============================================================
  // Event flags, one cell per flag
  wire [1:0] flag_set;
  wire [1:0] flag_clr;
  wire [1:0] flags;
  assign flag_set = {set_cmp && !wr_count, set_ovf && !wr_count};
  assign flag_clr[`TW8_FLAG_OVF] = ovf_ack_i || (wr_flags && wb_dat_i[`TW8_FLAG_OVF]);
  assign flag_clr[`TW8_FLAG_CMP] = cmp_ack_i || (wr_flags && wb_dat_i[`TW8_FLAG_CMP]);
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_flag
      tw8_flag u_flag
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(flag_set[gi]),
        .clr_i(flag_clr[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate
  assign ovf_flag_o = flags[`TW8_FLAG_OVF];
  assign cmp_flag_o = flags[`TW8_FLAG_CMP];

  // ============================================================
  // Control and direction registers
  // The force bit is a strobe and is never stored
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `TW8_RST_CTRL;
      dir_out <= `TW8_RST_DIR;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {1'b0, wb_dat_i[6:0]};
      if (wr_dir)
        dir_out <= wb_dat_i[`TW8_DIR_OUT];
    end
  end

  // ============================================================
  // Port pin drive
  // Pin shows the waveform only with an output select and output direction
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end
    else
    begin
      pin_o <= next_wave;
      pin_oe_n_o <= !(dir_out && (osel != 2'h0));
    end
  end

  // ============================================================
  // Wishbone answer
  // One wait-free ack per request; unmapped offsets read as zero
  reg [7:0] rd_byte;
  always @*
  begin
    case (wb_adr_i)
      `TW8_OFS_CTRL: rd_byte = ctrl;
      `TW8_OFS_COUNT: rd_byte = count;
      `TW8_OFS_COMPARE: rd_byte = cmp_buf;
      `TW8_OFS_FLAGS: rd_byte = {6'h00, flags};
      `TW8_OFS_DIR: rd_byte = {7'h00, dir_out};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
        wb_dat_o <= {24'h000000, rd_byte};
    end
  end

endmodule

//--- rtl/tw8_timer_regs.vh
/*
 * Register offsets, field positions and reset values of the 8-bit timer with
 * waveform modes.
 * Assumes a 32-bit Wishbone slave where each register takes one aligned word.
 */
`ifndef TW8_TIMER_REGS_VH
`define TW8_TIMER_REGS_VH

// ============================================================
// Register byte offsets
`define TW8_OFS_CTRL 8'h00
`define TW8_OFS_COUNT 8'h04
`define TW8_OFS_COMPARE 8'h08
`define TW8_OFS_FLAGS 8'h0c
`define TW8_OFS_DIR 8'h10

// ============================================================
// Control register fields
`define TW8_CTRL_FORCE 7
`define TW8_CTRL_MODE_LO 6
`define TW8_CTRL_OSEL_HI 5
`define TW8_CTRL_OSEL_LO 4
`define TW8_CTRL_MODE_HI 3
`define TW8_CTRL_CSEL_HI 2
`define TW8_CTRL_CSEL_LO 0

// ============================================================
// Flag register fields, write one to clear
`define TW8_FLAG_OVF 0
`define TW8_FLAG_CMP 1

// Direction register field
`define TW8_DIR_OUT 0

// ============================================================
// Waveform modes
`define TW8_MODE_NORMAL 2'h0
`define TW8_MODE_PHASE 2'h1
`define TW8_MODE_CLEAR 2'h2
`define TW8_MODE_FAST 2'h3

// Counter extremes
`define TW8_BOTTOM 8'h00
`define TW8_MAX 8'hff

// ============================================================
// Reset values
`define TW8_RST_CTRL 8'h00
`define TW8_RST_COUNT 8'h00
`define TW8_RST_COMPARE 8'h00
`define TW8_RST_DIR 1'b0

`endif

//--- rtl/tw8_flag.v
/*
 * One sticky event flag: hardware sets it, software or interrupt service
 * clears it.
 * Assumes set and clear pulses come from logic on the same clock.
 */
`timescale 1ns/1ps

module tw8_flag
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Events
  input wire set_i,
  input wire clr_i,
  // State
  output reg flag_o
);

  // ============================================================
  // Sticky flag
  // A set in the same cycle as a clear wins, so no event is lost
  always @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule

//--- rtl/tw8_cmp_buf.v
/*
 * Compare value store: a software-visible buffer and the active value that
 * the comparator uses.
 * Assumes the load strobe marks the top of the count in a PWM mode.
 */
`timescale 1ns/1ps
`include "tw8_timer_regs.vh"

module tw8_cmp_buf
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Software write
  input wire wr_i,
  input wire [7:0] wdata_i,
  // Mode and top strobe
  input wire pwm_i,
  input wire load_i,
  // Values
  output reg [7:0] buf_o,
  output reg [7:0] active_o
);

  // ============================================================
  // Buffered in PWM modes so a period never sees two compare values
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buf_o <= `TW8_RST_COMPARE;
      active_o <= `TW8_RST_COMPARE;
    end
    else
    begin
      if (wr_i)
        buf_o <= wdata_i;
      if (wr_i && !pwm_i)
        active_o <= wdata_i;
      else if (pwm_i && load_i)
        active_o <= buf_o;
    end
  end

endmodule

//--- verif/tw8_timer_chk.sv
/*
 * Port-level assertions for the waveform timer.
 * Assumes one clock domain and a synchronous, active high reset.
 */
`timescale 1ns/1ps

module tw8_timer_chk
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Timer events
  input wire tick_i,
  input wire ovf_ack_i,
  input wire cmp_ack_i,
  // Flags and waveform
  input wire ovf_flag_o,
  input wire cmp_flag_o,
  input wire wave_o,
  input wire pin_o,
  input wire pin_oe_n_o
);
  // ============================================================
  // Shared clocking
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Request waiting for its answer, and a write among them
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr;
    s_req ##0 wb_we_i;
  endsequence

  // ============================================================
  // Properties
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_reset;
    $fell(rst_i) |-> !ovf_flag_o && !cmp_flag_o && !wave_o && pin_oe_n_o && !wb_ack_o;
  endproperty
  property p_ovf_rise;
    $rose(ovf_flag_o) |-> $past(tick_i);
  endproperty
  property p_cmp_rise;
    $rose(cmp_flag_o) |-> $past(tick_i);
  endproperty
  property p_ovf_clr;
    ovf_ack_i && !tick_i |=> !ovf_flag_o;
  endproperty
  property p_cmp_clr;
    cmp_ack_i && !tick_i |=> !cmp_flag_o;
  endproperty
  // Reset edge is allowed since the state may have been cleared there
  property p_wave;
    $changed(wave_o) |-> $past(tick_i) || $past(rst_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i);
  endproperty
  property p_pin;
    !pin_oe_n_o |-> pin_o == wave_o;
  endproperty

  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow set without tick");
  a_cmp_rise: assert property (p_cmp_rise) else $error("compare flag set without tick");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared by service");
  a_cmp_clr: assert property (p_cmp_clr) else $error("compare flag not cleared by service");
  a_wave: assert property (p_wave) else $error("waveform moved without tick or write");
  a_pin: assert property (p_pin) else $error("pin differs from waveform");
  c_wr: cover property (s_wr);
endmodule

bind tw8_timer tw8_timer_chk u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tick_i(tick_i), .ovf_ack_i(ovf_ack_i),
  .cmp_ack_i(cmp_ack_i), .ovf_flag_o(ovf_flag_o), .cmp_flag_o(cmp_flag_o), .wave_o(wave_o),
  .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o)
);

//--- verif/tw8_timer_tb_top.sv
/*
 * Self-checking bench for the waveform timer: bus tasks and mode walks.
 * Assumes the register header of the design and a 20 MHz clock.
 */
`timescale 1ns/1ps
`include "tw8_timer_regs.vh"

module tw8_timer_tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tick_i, ovf_ack_i, cmp_ack_i;
  logic ovf_flag_o, cmp_flag_o, wave_o, pin_o, pin_oe_n_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int n_fail, num_checks;

  tw8_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tick_i(tick_i), .ovf_ack_i(ovf_ack_i),
    .cmp_ack_i(cmp_ack_i), .ovf_flag_o(ovf_flag_o), .cmp_flag_o(cmp_flag_o),
    .wave_o(wave_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));

  // ============================================================
  // Clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ============================================================
  // Helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Control byte: mode low at bit 6, mode high at bit 3, clock select stored only
  function logic [7:0] ctl(input logic [1:0] m, input logic [1:0] s);
    return {1'b0, m[0], s, m[1], 3'b001};
  endfunction

  // One classic cycle; read data is taken at the ack edge, bounded wait
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 100);
    // A missing answer counts as a mismatch
    if (t >= 100)
      n_fail++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // n timer ticks on consecutive cycles, then settle to the falling edge
  task ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      tick_i <= 1'b1;
    end
    @(posedge clk_i);
    tick_i <= 1'b0;
    @(negedge clk_i);
  endtask

  // Interrupt service pulses, kept away from ticks
  task svc(input logic o, input logic c);
    @(posedge clk_i);
    ovf_ack_i <= o;
    cmp_ack_i <= c;
    @(posedge clk_i);
    ovf_ack_i <= 1'b0;
    cmp_ack_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task flags(input logic [1:0] e);
    chk({30'h0, cmp_flag_o, ovf_flag_o}, {30'h0, e});
  endtask

  task summarize;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ============================================================
  // Watchdog, well beyond the roughly 1200 cycles the walk needs
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    summarize();
  end

  // ============================================================
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    tick_i = 1'b0;
    ovf_ack_i = 1'b0;
    cmp_ack_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state and an unmapped read
    rchk(`TW8_OFS_CTRL, 8'h00);
    rchk(`TW8_OFS_COUNT, 8'h00);
    rchk(`TW8_OFS_COMPARE, 8'h00);
    rchk(`TW8_OFS_FLAGS, 8'h00);
    rchk(8'h14, 8'h00);
    chk({30'h0, wave_o, pin_oe_n_o}, 32'h1);
    // Normal mode: wrap at the top sets overflow on the same tick
    wb(1'b1, `TW8_OFS_COUNT, 8'hfe);
    ticks(1);
    flags(2'h0);
    ticks(1);
    flags(2'h1);
    rchk(`TW8_OFS_COUNT, 8'h00);
    svc(1'b1, 1'b0);
    flags(2'h0);
    // Clear-on-match, toggle output, top of three
    wb(1'b1, `TW8_OFS_CTRL, ctl(`TW8_MODE_CLEAR, 2'h1));
    wb(1'b1, `TW8_OFS_COMPARE, 8'h03);
    wb(1'b1, `TW8_OFS_COUNT, 8'h00);
    ticks(3);
    chk({30'h0, wave_o, cmp_flag_o}, 32'h0);
    ticks(1);
    chk({30'h0, wave_o, cmp_flag_o}, 32'h3);
    rchk(`TW8_OFS_COUNT, 8'h00);
    ticks(4);
    chk({31'h0, wave_o}, 32'h0);
    // Compare lowered below the count: match missed until the wrap
    wb(1'b1, `TW8_OFS_COUNT, 8'h10);
    wb(1'b1, `TW8_OFS_COMPARE, 8'h05);
    svc(1'b1, 1'b1);
    ticks(8'hef);
    flags(2'h0);
    ticks(1);
    flags(2'h1);
    ticks(6);
    flags(2'h3);
    // Fast PWM, non-inverted, pin enabled by direction
    wb(1'b1, `TW8_OFS_CTRL, ctl(`TW8_MODE_FAST, 2'h2));
    wb(1'b1, `TW8_OFS_COMPARE, 8'h80);
    ticks(0);
    chk({31'h0, pin_oe_n_o}, 32'h1);
    wb(1'b1, `TW8_OFS_DIR, 8'h01);
    ticks(0);
    chk({31'h0, pin_oe_n_o}, 32'h0);
    wb(1'b1, `TW8_OFS_COUNT, 8'hfd);
    svc(1'b1, 1'b1);
    ticks(2);
    flags(2'h0);
    // Overflow and set of the output both come on the tick at MAX
    ticks(1);
    chk({30'h0, wave_o, ovf_flag_o}, 32'h3);
    rchk(`TW8_OFS_COUNT, 8'h00);
    ticks(8'h81);
    chk({31'h0, wave_o}, 32'h0);
    chk({31'h0, pin_o}, 32'h0);
    // New compare waits in the buffer until the top
    wb(1'b1, `TW8_OFS_COMPARE, 8'h40);
    rchk(`TW8_OFS_COMPARE, 8'h40);
    svc(1'b1, 1'b1);
    ticks(8'h7d);
    flags(2'h0);
    wb(1'b1, `TW8_OFS_CTRL, ctl(`TW8_MODE_FAST, 2'h3));
    ticks(2);
    chk({31'h0, wave_o}, 32'h0);
    ticks(8'h41);
    chk({30'h0, wave_o, cmp_flag_o}, 32'h3);
    // Phase-correct: forced state at the top, matches on both slopes
    wb(1'b1, `TW8_OFS_CTRL, ctl(`TW8_MODE_PHASE, 2'h2));
    wb(1'b1, `TW8_OFS_COMPARE, 8'hf0);
    wb(1'b1, `TW8_OFS_COUNT, 8'hfd);
    svc(1'b1, 1'b1);
    ticks(3);
    chk({31'h0, wave_o}, 32'h0);
    rchk(`TW8_OFS_COUNT, 8'hfe);
    ticks(8'h0f);
    chk({31'h0, wave_o}, 32'h1);
    ticks(8'hef);
    chk({31'h0, ovf_flag_o}, 32'h0);
    ticks(1);
    chk({31'h0, ovf_flag_o}, 32'h1);
    rchk(`TW8_OFS_COUNT, 8'h01);
    ticks(8'hf0);
    chk({31'h0, wave_o}, 32'h0);
    summarize();
  end
endmodule
